/* File: rtl/rxbuf_pkg.sv */
package rxbuf_pkg;

    // Receive buffer geometry
    localparam int BUF_DEPTH = 62;
    localparam int IDX_W = 6;
    localparam logic [5:0] LAST_IDX = 6'h3d;
    localparam logic [5:0] IDX_STEP = 6'h01;
    localparam logic [5:0] RD_RESET = 6'h00;
    localparam logic [5:0] WR_RESET = 6'h01;
    localparam logic [5:0] NXT_RESET = 6'h00;
    localparam logic [6:0] DEPTH_W7 = 7'h3e;
    localparam logic [6:0] SPACE_MAX = 7'h3d;
    localparam logic [6:0] ONE_W7 = 7'h01;
    localparam logic [7:0] NULL_BYTE = 8'h00;

    // Transmit load queues
    localparam int Q_NUM = 4;
    localparam int Q_LOCS = 7;
    localparam logic [2:0] Q_LAST_LOC = 3'h6;
    localparam logic [2:0] Q_PAST_LOC = 3'h7;
    localparam logic [2:0] LOC_STEP = 3'h1;
    localparam logic [1:0] QSEL_STEP = 2'h1;
    localparam logic [7:0] Q_LEN_DEF = 8'h00;
    localparam logic [7:0] FILL_A = 8'hd3;
    localparam logic [7:0] FILL_B = 8'hc2;
    localparam logic [6:0][7:0] Q_DEFAULT =
        {FILL_B, FILL_A, FILL_B, FILL_A, FILL_B, FILL_A, Q_LEN_DEF};
    localparam int CMD_LOC_HI = 3;
    localparam int CMD_LOC_LO = 1;
    localparam int CMD_ODD_BIT = 0;

    // Command bytes
    localparam logic [7:0] CMD_TX_CLEAR = 8'h20;
    localparam logic [7:0] CMD_RD_BUF = 8'h91;
    localparam logic [7:0] CMD_RD_NXT = 8'h93;
    localparam logic [7:0] CMD_RX_CLEAR = 8'he0;
    localparam logic [7:0] ADV_FIRST = 8'hb0;
    localparam logic [7:0] ADV_LAST = 8'hbc;
    localparam logic [7:0] FILL_FIRST = 8'hc0;
    localparam logic [7:0] FILL_LAST = 8'hcc;
    localparam logic [7:0] RB_FIRST = 8'hc1;
    localparam logic [7:0] RB_LAST = 8'hcd;
    localparam logic [7:0] REG_A_FIRST = 8'h01;
    localparam logic [7:0] REG_A_LAST = 8'h1b;
    localparam logic [7:0] REG_B_FIRST = 8'h95;
    localparam logic [7:0] REG_B_LAST = 8'h9b;

    typedef enum logic [1:0] {KIND_PREAMBLE, KIND_DATA, KIND_STOP} rx_kind_e;
    typedef enum logic [2:0] {S_CMD, S_REG, S_RXRD, S_QWR, S_QRD, S_SKIP} spi_state_e;

    typedef struct packed {
        rx_kind_e kind;
        logic [7:0] data;
        logic err;
    } rx_char_s;

    typedef struct packed {
        rx_char_s ch;
        logic first;
    } rx_evt_s;

    typedef struct packed {
        logic empty;
        logic stop;
        logic overflow;
        logic first_byte;
        logic byte_error;
        logic last_byte;
        logic [5:0] read_index;
        logic [5:0] write_index;
        logic [5:0] next_unread_message_index;
        logic [6:0] space;
    } rx_status_s;

    typedef struct packed {
        logic synced;
        logic in_msg;
        logic first_pend;
        logic req;
        rx_evt_s evt;
        logic [2:0] ack_sync;
    } link_s;

    typedef struct packed {
        spi_state_e st;
        logic [5:0] rd;
        logic [5:0] wr;
        logic [5:0] nxt;
        logic [61:0][7:0] mem;
        logic [61:0] first;
        logic [61:0] err;
        logic [61:0] last;
        logic stop_st;
        logic ovf_st;
        logic past_end;
        logic read_any;
        logic [3:0][6:0][7:0] q;
        logic [1:0] loading_queue_select;
        logic [1:0] tx_q;
        logic tx_ovf;
        logic [2:0] q_loc;
        logic [7:0] miso;
        logic [7:0] tx_rd_data;
        logic [7:0] reg_addr;
        logic [7:0] reg_wdata;
        logic reg_wstrobe;
        logic rx_clr;
        logic [2:0] req_sync;
        logic ack;
    } core_s;

endpackage : rxbuf_pkg

/* File: rtl/rx_message_buffer.sv */
`timescale 1ns/1ps
// Functional notes
// - 62-byte circular buffer, written only by the receiver, read only by host.
// - Read index resets 00h, write index 01h, next-message index 00h.
// - Read index one below write index means empty; reads then return zero.
// - Command E0h resets all three indices and zeroes all 62 bytes.
// - E0h also asynchronously resets the receiver; it resyncs on preamble or idle.
// - Preamble is not stored; data stored in order until stop or preamble.
// - Stop stores 00h and sets stop status; cleared by empty or next preamble.
// - Byte at read index reports first, error and last flags.
// - Data not preceded by a valid preamble is dropped.
// - Unterminated message ends at the next preamble, no null stored.
// - Preamble then stop stores a single 00h null message.
// - Write index halts one below read index; later bytes overwrite, set overflow.
// - Overflow clears when the host reads and frees space.
// - 91h reads from read index, 93h from next-message index; index advances.
// - Reads past message end return 00h; never advance into next message.
// - B0h-BCh bump load-queue select unless it would reach the transmit queue (then flag overflow), then write from location code[3:1].
// - C0h-CCh write current load queue from code[3:1]; past 6 ignored.
// - C1h-CDh read current load queue from code[3:1]; past 6 reads zero.
// - 20h restores queue defaults and zeroes both queue selects.
// - Bytes 01h-1Bh and 95h-9Bh open register accesses.
// - Index advances only after a full byte; read bytes are cleared.
module rx_message_buffer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_clk,
    input wire logic rx_valid,
    input rxbuf_pkg::rx_char_s rx_char,
    input wire logic rx_idle,
    output logic rx_ready,
    input wire logic cs_active,
    input wire logic byte_done,
    input wire logic [7:0] mosi_byte,
    output logic [7:0] miso_byte,
    output logic reg_sel,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wstrobe,
    input wire logic [7:0] reg_rdata,
    output logic [1:0] loading_queue_select,
    output logic [1:0] tx_queue_select,
    output logic tx_overflow,
    input wire logic tx_done,
    input wire logic [2:0] tx_rd_loc,
    output logic [7:0] tx_rd_data,
    output rxbuf_pkg::rx_status_s status
);

    localparam rxbuf_pkg::core_s CORE_RST = '{
        st: rxbuf_pkg::S_CMD, rd: rxbuf_pkg::RD_RESET, wr: rxbuf_pkg::WR_RESET,
        nxt: rxbuf_pkg::NXT_RESET, q: {rxbuf_pkg::Q_NUM{rxbuf_pkg::Q_DEFAULT}},
        default: '0};
    localparam rxbuf_pkg::link_s LINK_RST = '{evt: '0, default: '0};

    rxbuf_pkg::core_s core_r, core_nxt;
    rxbuf_pkg::link_s link_r, link_nxt;
    logic rx_arst_n;
    logic link_ready;
    logic evt_take;
    logic cmd_take;
    logic rd_take;
    logic [6:0] unread;

    function automatic logic [5:0] idx_inc(input logic [5:0] i);
        return (i == rxbuf_pkg::LAST_IDX) ? rxbuf_pkg::RD_RESET : i + rxbuf_pkg::IDX_STEP;
    endfunction : idx_inc

    function automatic logic buf_empty(input rxbuf_pkg::core_s c);
        return idx_inc(c.rd) == c.wr;
    endfunction : buf_empty

    // Stops at a stored stop byte or at the first byte of the next message
    function automatic logic can_read(input rxbuf_pkg::core_s c);
        return !buf_empty(c) && !c.past_end && !(c.read_any && c.first[idx_inc(c.rd)]);
    endfunction : can_read

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_range

    // Receiver side, reset also by the clear command
    assign rx_arst_n = rst_n & ~core_r.rx_clr;
    assign link_ready = (link_r.ack_sync[2] == link_r.req) &&
                        (link_r.ack_sync[1] == link_r.ack_sync[2]);
    assign rx_ready = link_ready;

    always_comb begin
        link_nxt = link_r;
        link_nxt.ack_sync = {link_r.ack_sync[1:0], core_r.ack};
        if (rx_idle) begin
            link_nxt.synced = 1'b1;
        end
        if (rx_valid && link_ready) begin
            case (rx_char.kind)
                rxbuf_pkg::KIND_PREAMBLE: begin
                    if (!link_r.synced) begin
                        // Resync preamble opens no message
                        link_nxt.synced = 1'b1;
                    end else begin
                        link_nxt.in_msg = 1'b1;
                        link_nxt.first_pend = 1'b1;
                        link_nxt.evt = '{ch: rx_char, first: 1'b0};
                        link_nxt.req = ~link_r.req;
                    end
                end
                rxbuf_pkg::KIND_DATA, rxbuf_pkg::KIND_STOP: begin
                    if (link_r.synced && link_r.in_msg) begin
                        link_nxt.evt = '{ch: rx_char, first: link_r.first_pend};
                        link_nxt.req = ~link_r.req;
                        link_nxt.first_pend = 1'b0;
                        link_nxt.in_msg = (rx_char.kind == rxbuf_pkg::KIND_DATA);
                    end
                end
                default: begin
                    link_nxt.first_pend = link_r.first_pend;
                end
            endcase
        end
    end

    always_ff @(posedge rx_clk or negedge rx_arst_n) begin
        if (!rx_arst_n) begin
            link_r <= LINK_RST;
        end else begin
            link_r <= link_nxt;
        end
    end

    // Host side
    assign cmd_take = cs_active && byte_done && (core_r.st == rxbuf_pkg::S_CMD);
    assign rd_take = cs_active && byte_done && (core_r.st == rxbuf_pkg::S_RXRD) &&
                     can_read(core_r);
    assign evt_take = !core_r.rx_clr && (core_r.req_sync[1] == core_r.req_sync[2]) &&
                      (core_r.req_sync[2] != core_r.ack);

    always_comb begin
        logic [5:0] h;
        h = idx_inc(core_r.rd);
        core_nxt = core_r;
        core_nxt.req_sync = {core_r.req_sync[1:0], link_r.req};
        core_nxt.reg_wstrobe = 1'b0;
        core_nxt.rx_clr = 1'b0;
        if (!cs_active) begin
            core_nxt.st = rxbuf_pkg::S_CMD;
        end else if (byte_done) begin
            case (core_r.st)
                rxbuf_pkg::S_CMD: begin
                    core_nxt.st = rxbuf_pkg::S_SKIP;
                    core_nxt.q_loc = mosi_byte[rxbuf_pkg::CMD_LOC_HI:rxbuf_pkg::CMD_LOC_LO];
                    core_nxt.read_any = 1'b0;
                    core_nxt.past_end = 1'b0;
                    if (in_range(mosi_byte, rxbuf_pkg::REG_A_FIRST, rxbuf_pkg::REG_A_LAST) ||
                        in_range(mosi_byte, rxbuf_pkg::REG_B_FIRST, rxbuf_pkg::REG_B_LAST)) begin
                        core_nxt.st = rxbuf_pkg::S_REG;
                        core_nxt.reg_addr = mosi_byte;
                    end else if (mosi_byte == rxbuf_pkg::CMD_RD_BUF) begin
                        core_nxt.st = rxbuf_pkg::S_RXRD;
                    end else if (mosi_byte == rxbuf_pkg::CMD_RD_NXT) begin
                        core_nxt.st = rxbuf_pkg::S_RXRD;
                        core_nxt.rd = core_r.nxt;
                    end else if (in_range(mosi_byte, rxbuf_pkg::ADV_FIRST, rxbuf_pkg::ADV_LAST)
                                 && !mosi_byte[rxbuf_pkg::CMD_ODD_BIT]) begin
                        core_nxt.st = rxbuf_pkg::S_QWR;
                        // A full queue ring refuses the step and flags it
                        if (core_r.loading_queue_select + rxbuf_pkg::QSEL_STEP != core_r.tx_q) begin
                            core_nxt.loading_queue_select =
                                core_r.loading_queue_select + rxbuf_pkg::QSEL_STEP;
                        end else begin
                            core_nxt.tx_ovf = 1'b1;
                        end
                    end else if (in_range(mosi_byte, rxbuf_pkg::FILL_FIRST,
                                          rxbuf_pkg::FILL_LAST)
                                 && !mosi_byte[rxbuf_pkg::CMD_ODD_BIT]) begin
                        core_nxt.st = rxbuf_pkg::S_QWR;
                    end else if (in_range(mosi_byte, rxbuf_pkg::RB_FIRST, rxbuf_pkg::RB_LAST)
                                 && mosi_byte[rxbuf_pkg::CMD_ODD_BIT]) begin
                        core_nxt.st = rxbuf_pkg::S_QRD;
                    end else if (mosi_byte == rxbuf_pkg::CMD_TX_CLEAR) begin
                        core_nxt.q = {rxbuf_pkg::Q_NUM{rxbuf_pkg::Q_DEFAULT}};
                        core_nxt.loading_queue_select = '0;
                        core_nxt.tx_q = '0;
                        core_nxt.tx_ovf = 1'b0;
                    end else if (mosi_byte == rxbuf_pkg::CMD_RX_CLEAR) begin
                        core_nxt.rd = rxbuf_pkg::RD_RESET;
                        core_nxt.wr = rxbuf_pkg::WR_RESET;
                        core_nxt.nxt = rxbuf_pkg::NXT_RESET;
                        core_nxt.mem = '0;
                        core_nxt.first = '0;
                        core_nxt.err = '0;
                        core_nxt.last = '0;
                        core_nxt.stop_st = 1'b0;
                        core_nxt.ovf_st = 1'b0;
                        core_nxt.rx_clr = 1'b1;
                        core_nxt.req_sync = '0;
                        core_nxt.ack = 1'b0;
                    end
                end
                rxbuf_pkg::S_REG: begin
                    core_nxt.reg_wdata = mosi_byte;
                    core_nxt.reg_wstrobe = 1'b1;
                end
                rxbuf_pkg::S_RXRD: begin
                    if (can_read(core_r)) begin
                        // Advance and clear only once the whole byte went out
                        core_nxt.mem[h] = rxbuf_pkg::NULL_BYTE;
                        core_nxt.first[h] = 1'b0;
                        core_nxt.err[h] = 1'b0;
                        core_nxt.last[h] = 1'b0;
                        core_nxt.rd = h;
                        core_nxt.read_any = 1'b1;
                        core_nxt.ovf_st = 1'b0;
                        if (core_r.last[h]) begin
                            core_nxt.past_end = 1'b1;
                            core_nxt.nxt = h;
                        end
                        if (idx_inc(h) == core_r.wr) begin
                            core_nxt.stop_st = 1'b0;
                        end
                    end
                end
                rxbuf_pkg::S_QWR: begin
                    if (core_r.q_loc <= rxbuf_pkg::Q_LAST_LOC) begin
                        core_nxt.q[core_nxt.loading_queue_select][core_r.q_loc] = mosi_byte;
                        core_nxt.q_loc = core_r.q_loc + rxbuf_pkg::LOC_STEP;
                    end
                end
                rxbuf_pkg::S_QRD: begin
                    if (core_r.q_loc <= rxbuf_pkg::Q_LAST_LOC) begin
                        core_nxt.q_loc = core_r.q_loc + rxbuf_pkg::LOC_STEP;
                    end
                end
                rxbuf_pkg::S_SKIP: begin
                    core_nxt.st = rxbuf_pkg::S_SKIP;
                end
                default: begin
                    core_nxt.st = rxbuf_pkg::S_CMD;
                end
            endcase
        end
        // Store after the read so a set in the same cycle wins; a clear drops it
        if (evt_take && !core_nxt.rx_clr) begin
            core_nxt.ack = core_r.req_sync[2];
            if (link_r.evt.ch.kind == rxbuf_pkg::KIND_PREAMBLE) begin
                core_nxt.stop_st = 1'b0;
            end else begin
                core_nxt.mem[core_nxt.wr] = (link_r.evt.ch.kind == rxbuf_pkg::KIND_STOP) ?
                    rxbuf_pkg::NULL_BYTE : link_r.evt.ch.data;
                core_nxt.first[core_nxt.wr] = link_r.evt.first;
                core_nxt.err[core_nxt.wr] = link_r.evt.ch.err;
                core_nxt.last[core_nxt.wr] = (link_r.evt.ch.kind == rxbuf_pkg::KIND_STOP);
                if (link_r.evt.ch.kind == rxbuf_pkg::KIND_STOP) begin
                    core_nxt.stop_st = 1'b1;
                end
                if (idx_inc(core_nxt.wr) != core_nxt.rd) begin
                    core_nxt.wr = idx_inc(core_nxt.wr);
                end else begin
                    core_nxt.ovf_st = 1'b1;
                end
            end
        end
        if (tx_done && (core_nxt.tx_q != core_nxt.loading_queue_select)) begin
            core_nxt.q[core_nxt.tx_q] = rxbuf_pkg::Q_DEFAULT;
            core_nxt.tx_q = core_nxt.tx_q + rxbuf_pkg::QSEL_STEP;
        end
        core_nxt.tx_rd_data = (tx_rd_loc <= rxbuf_pkg::Q_LAST_LOC) ?
            core_r.q[core_r.tx_q][tx_rd_loc] : rxbuf_pkg::NULL_BYTE;
        // Unterminated message: its end is where the next one begins
        if ((core_nxt.st == rxbuf_pkg::S_RXRD) && core_nxt.read_any &&
            !buf_empty(core_nxt) && core_nxt.first[idx_inc(core_nxt.rd)]) begin
            core_nxt.nxt = core_nxt.rd;
        end
        case (core_nxt.st)
            rxbuf_pkg::S_RXRD: begin
                core_nxt.miso = can_read(core_nxt) ?
                    core_nxt.mem[idx_inc(core_nxt.rd)] : rxbuf_pkg::NULL_BYTE;
            end
            rxbuf_pkg::S_QRD: begin
                core_nxt.miso = (core_nxt.q_loc <= rxbuf_pkg::Q_LAST_LOC) ?
                    core_nxt.q[core_nxt.loading_queue_select][core_nxt.q_loc] :
                    rxbuf_pkg::NULL_BYTE;
            end
            rxbuf_pkg::S_REG: begin
                core_nxt.miso = reg_rdata;
            end
            default: begin
                core_nxt.miso = rxbuf_pkg::NULL_BYTE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_r <= CORE_RST;
        end else begin
            core_r <= core_nxt;
        end
    end

    assign unread = (core_r.wr > core_r.rd) ?
        ({1'b0, core_r.wr} - {1'b0, core_r.rd} - rxbuf_pkg::ONE_W7) :
        ({1'b0, core_r.wr} + rxbuf_pkg::DEPTH_W7 - {1'b0, core_r.rd} - rxbuf_pkg::ONE_W7);

    always_comb begin
        status.empty = buf_empty(core_r);
        status.stop = core_r.stop_st;
        status.overflow = core_r.ovf_st;
        status.first_byte = !buf_empty(core_r) && core_r.first[idx_inc(core_r.rd)];
        status.byte_error = !buf_empty(core_r) && core_r.err[idx_inc(core_r.rd)];
        status.last_byte = !buf_empty(core_r) && core_r.last[idx_inc(core_r.rd)];
        status.read_index = core_r.rd;
        status.write_index = core_r.wr;
        status.next_unread_message_index = core_r.nxt;
        status.space = rxbuf_pkg::SPACE_MAX - unread;
    end

    assign miso_byte = core_r.miso;
    assign reg_sel = cs_active && (core_r.st == rxbuf_pkg::S_REG);
    assign reg_addr = core_r.reg_addr;
    assign reg_wdata = core_r.reg_wdata;
    assign reg_wstrobe = core_r.reg_wstrobe;
    assign loading_queue_select = core_r.loading_queue_select;
    assign tx_queue_select = core_r.tx_q;
    assign tx_overflow = core_r.tx_ovf;
    assign tx_rd_data = core_r.tx_rd_data;

    a_empty_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_r.st == rxbuf_pkg::S_RXRD) && buf_empty(core_r) |-> core_r.miso == '0)
        else $error("empty buffer read not zero");
    a_clear_indices: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cmd_take && (mosi_byte == rxbuf_pkg::CMD_RX_CLEAR) |=>
        core_r.rd == rxbuf_pkg::RD_RESET && core_r.wr == rxbuf_pkg::WR_RESET &&
        core_r.nxt == rxbuf_pkg::NXT_RESET && core_r.mem == '0 && core_r.rx_clr)
        else $error("receive clear incomplete");
    a_clear_resets_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
        core_r.rx_clr |-> !rx_arst_n)
        else $error("receiver not reset by clear");
    a_write_halts: assert property (@(posedge ref_clk) disable iff (!rst_n)
        core_r.wr != core_r.rd)
        else $error("write index reached read index");
    a_read_advances: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take |=> core_r.rd == idx_inc($past(core_r.rd)) && !core_r.ovf_st)
        else $error("read index or overflow wrong after read");
    a_past_end_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_r.st == rxbuf_pkg::S_RXRD) && core_r.past_end |->
        core_r.miso == '0 ##1 (core_r.rd == $past(core_r.rd) || !cs_active ||
        core_r.st != rxbuf_pkg::S_RXRD || core_r.rx_clr))
        else $error("read ran past message end");
    a_next_msg_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cmd_take && (mosi_byte == rxbuf_pkg::CMD_RD_NXT) |=> core_r.rd == $past(core_r.nxt))
        else $error("93h did not start at next message");
    a_stop_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evt_take && (link_r.evt.ch.kind == rxbuf_pkg::KIND_STOP) |=> core_r.stop_st)
        else $error("stop status not set");
    a_tx_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cmd_take && (mosi_byte == rxbuf_pkg::CMD_TX_CLEAR) |=>
        core_r.loading_queue_select == '0 && core_r.tx_q == '0)
        else $error("transmit clear left selects");
    a_unframed_drop: assert property (@(posedge rx_clk) disable iff (!rx_arst_n)
        rx_valid && link_ready && (rx_char.kind == rxbuf_pkg::KIND_DATA) && !link_r.in_msg
        |=> link_r.req == $past(link_r.req))
        else $error("unframed data forwarded");

    c_read_msg: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rd_take ##[1:100] rd_take);
    c_rx_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) core_r.rx_clr);
    c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(core_r.ovf_st));

endmodule : rx_message_buffer

/* File: tb/rx_source.sv */
`timescale 1ns/1ps
module rx_source (
    input wire logic rx_clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output rxbuf_pkg::rx_char_s rx_char
);
    initial rx_valid = 1'b0;
    initial rx_char = '0;
    // Char held until taken; data inverted once released
    task automatic send(input rxbuf_pkg::rx_kind_e k, input logic [7:0] d, input logic e);
        logic rdy;
        @(posedge rx_clk);
        #1 rx_valid = 1'b1;
        rx_char = '{k, d, e};
        do begin
            @(negedge rx_clk);
            rdy = rx_ready;
            @(posedge rx_clk);
        end while (!rdy);
        #1 rx_valid = 1'b0;
        rx_char.data = ~d;
    endtask : send
endmodule : rx_source

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam rxbuf_pkg::rx_kind_e PRE = rxbuf_pkg::KIND_PREAMBLE;
    localparam rxbuf_pkg::rx_kind_e DAT = rxbuf_pkg::KIND_DATA;
    localparam rxbuf_pkg::rx_kind_e STP = rxbuf_pkg::KIND_STOP;
    logic ref_clk = 0, rx_clk = 0, rst_n = 0, rx_idle = 1, cs_active = 0, byte_done = 0;
    logic rx_valid, rx_ready, reg_sel, reg_wstrobe;
    logic [7:0] mosi_byte = 0, miso_byte, r, reg_addr, q[$], v[8];
    logic [7:0] ra[5] = '{8'h01, 8'h1b, 8'h95, 8'h9b, 8'h1c};
    logic [1:0] loading_queue_select;
    rxbuf_pkg::rx_char_s rx_char;
    rxbuf_pkg::rx_status_s st;
    int failures = 0, n_compared = 0, seed = 32'h7295;
    initial forever #50 ref_clk = ~ref_clk;
    initial #1.7 forever #3 rx_clk = ~rx_clk;
    rx_source src (.rx_clk(rx_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_char(rx_char));
    rx_message_buffer uut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_clk(rx_clk), .rx_valid(rx_valid),
        .rx_char(rx_char), .rx_idle(rx_idle), .rx_ready(rx_ready), .cs_active(cs_active),
        .byte_done(byte_done), .mosi_byte(mosi_byte), .miso_byte(miso_byte), .reg_sel(reg_sel),
        .reg_addr(reg_addr), .reg_wdata(), .reg_wstrobe(reg_wstrobe), .reg_rdata(8'h5a),
        .loading_queue_select(loading_queue_select), .tx_queue_select(), .tx_overflow(),
        .tx_done(1'b0), .tx_rd_loc(3'h0), .tx_rd_data(), .status(st));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] b);
        cs_active = 1'b1;
        mosi_byte = b;
        byte_done = 1'b1;
        @(posedge ref_clk);
        #2 byte_done = 1'b0;
        @(posedge ref_clk);
        #2 r = miso_byte;
    endtask : xfer
    task automatic wt(input int n);
        cs_active = 1'b0;
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : wt
    task automatic rx(input rxbuf_pkg::rx_kind_e k, input logic [7:0] d, input logic e);
        src.send(k, d, e);
        if (k != PRE) q.push_back(k == STP ? 8'h00 : d);
    endtask : rx
    task automatic rd(input logic [7:0] c, input int n, input int x);
        xfer(c);
        repeat (n) begin
            chk("rx byte", r, q.pop_front());
            xfer(8'h00);
        end
        repeat (x) begin
            chk("past end", r, 8'h00);
            xfer(8'h00);
        end
        wt(1);
    endtask : rd
    task automatic end_sim;
        $display("Compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // Whole run needs well under 100 us
    initial begin
        #1ms failures++;
        end_sim();
    end
    initial begin
        wt(5);
        rst_n = 1'b1;
        chk("empty", 8'(st.empty), 8'h01);
        chk("rd idx", 8'(st.read_index), 8'h00);
        chk("wr idx", 8'(st.write_index), 8'h01);
        wt(2);
        rx_idle = 1'b0;
        foreach (v[i]) v[i] = $random(seed);
        src.send(DAT, v[3], 1'b0);
        rx(PRE, 0, 0);
        rx(DAT, v[0], 1);
        rx(DAT, v[1], 0);
        rx(STP, 0, 0);
        rx(PRE, 0, 0);
        rx(DAT, v[2], 0);
        rx(PRE, 0, 0);
        rx(STP, 0, 0);
        wt(10);
        chk("stop", 8'(st.stop), 8'h01);
        chk("first", 8'(st.first_byte), 8'h01);
        chk("error", 8'(st.byte_error), 8'h01);
        rd(8'h91, 3, 1);
        rd(8'h93, 1, 1);
        chk("last", 8'(st.last_byte), 8'h01);
        rd(8'h91, 1, 0);
        chk("empty", {st.empty, st.stop}, 8'h02);
        $display("messages done");
        rx(PRE, 0, 0);
        repeat (62) src.send(DAT, 8'($random(seed)), 1'b0);
        wt(10);
        chk("overflow", {st.overflow, st.space}, 8'h81);
        xfer(8'h91);
        xfer(8'h00);
        wt(1);
        chk("overflow", 8'(st.overflow), 8'h00);
        xfer(8'he0);
        wt(3);
        chk("indices", {st.read_index, st.empty}, 8'h01);
        chk("indices", {st.next_unread_message_index, st.write_index[1:0]}, 8'h01);
        q.delete();
        rd(8'h91, 0, 1);
        rx_idle = 1'b1;
        wt(2);
        rx_idle = 1'b0;
        rx(PRE, 0, 0);
        rx(DAT, v[1], 0);
        rx(STP, 0, 0);
        wt(10);
        rd(8'h91, 2, 0);
        $display("overflow and clear done");
        v[0] = 8'h03;
        xfer(8'hc0);
        foreach (v[i]) xfer(v[i]);
        wt(1);
        xfer(8'hc3);
        for (int i = 1; i < 8; i++) begin
            chk("queue", r, i < 7 ? v[i] : 8'h00);
            xfer(8'h00);
        end
        wt(1);
        xfer(8'hb4);
        xfer(v[7]);
        wt(1);
        chk("load sel", 8'(loading_queue_select), 8'h01);
        xfer(8'hc5);
        chk("queue", r, v[7]);
        xfer(8'h00);
        chk("queue", r, 8'hd3);
        wt(1);
        xfer(8'h20);
        wt(1);
        chk("load sel", 8'(loading_queue_select), 8'h00);
        xfer(8'hc1);
        chk("queue", r, 8'h00);
        wt(1);
        foreach (ra[i]) begin
            xfer(ra[i]);
            chk("reg sel", {reg_sel, reg_addr[6:0]}, i < 4 ? {1'b1, ra[i][6:0]} : {1'b0, ra[3][6:0]});
            wt(1);
        end
        $display("queues and registers done");
        end_sim();
    end
endmodule : tb_top
